// [shared/rrs_params.svh]
// constants for the return, rotate and sleep decode block
`ifndef RRS_PARAMS_SVH
`define RRS_PARAMS_SVH

// opcode patterns
`define RRS_OP_RETURN        14'h0008
`define RRS_OP_SLEEP         14'h0063
`define RRS_ROT_LEFT_PFX     6'h0D
`define RRS_ROT_RIGHT_PFX    6'h0C
`define RRS_DEST_BIT         7

// instruction cycle phases
`define RRS_Q1               2'h0
`define RRS_Q2               2'h1
`define RRS_Q3               2'h2
`define RRS_Q4               2'h3

// bus widths
`define RRS_ADDR_W           32
`define RRS_DATA_W           32

// register byte addresses
`define RRS_REG_CTRL         32'h0000_0000
`define RRS_REG_STATUS       32'h0000_0004
`define RRS_REG_ACCUM        32'h0000_0008
`define RRS_REG_LASTPC       32'h0000_000C

// control register fields and reset
`define RRS_CTRL_EN_BIT      0
`define RRS_CTRL_WAKE_BIT    1
`define RRS_CTRL_EN_RESET    1'b1

// core state reset values
`define RRS_CARRY_RESET      1'b0
`define RRS_TIMEOUT_RESET    1'b1
`define RRS_PDOWN_RESET      1'b1
`define RRS_ACCUM_RESET      8'h00

// bus responses
`define RRS_RESP_OKAY        2'h0
`define RRS_RESP_SLVERR      2'h2

`endif

// [shared/rrs_pkg.sv]
// types for the return, rotate and sleep decode block
`include "rrs_params.svh"

package rrs_pkg;

	// decode sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ROT,
		ST_RET1,
		ST_RET2,
		ST_SLP1,
		ST_SLEEP
	} op_state_type;

	// bus master to slave
	typedef struct packed {
		logic                     awvalid;
		logic [`RRS_ADDR_W-1:0]   awaddr;
		logic                     wvalid;
		logic [`RRS_DATA_W-1:0]   wdata;
		logic [`RRS_DATA_W/8-1:0] wstrb;
		logic                     bready;
		logic                     arvalid;
		logic [`RRS_ADDR_W-1:0]   araddr;
		logic                     rready;
	} axil_req_type;

	// bus slave to master
	typedef struct packed {
		logic                     awready;
		logic                     wready;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     arready;
		logic                     rvalid;
		logic [`RRS_DATA_W-1:0]   rdata;
		logic [1:0]               rresp;
	} axil_rsp_type;

	// file register port
	typedef struct packed {
		logic       rdEn;
		logic       wrEn;
		logic [6:0] addr;
		logic [7:0] wrData;
	} regfile_req_type;

endpackage : rrs_pkg

// [rtl/return_rotate_sleep_ops.sv]
// decode and execute of return, rotate through carry and sleep
`timescale 1ns/1ps
`default_nettype none
`include "rrs_params.svh"

// Notes on behaviour
// - return opcode 0x008 pops stack, top entry loads pc, status untouched
// - return takes two cycles: pop in last phase, second cycle idle
// - rotate-left pattern shifts selected register left through carry only
// - rotate-left destination 0 goes to accumulator, 1 back to register
// - rotate-right pattern shifts selected register right through carry only
// - rotate-right destination 0 goes to accumulator, 1 back to register
// - rotate is one cycle: decode, read, process, write destination
// - sleep sets timeout flag and clears power-down flag
// - sleep clears watchdog counter and its prescaler
// - after sleep the core halts its oscillator
module return_rotate_sleep_ops #(
	parameter int PC_W = 13
) (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   reset_n,
	// register bus
	input  wire rrs_pkg::axil_req_type  axilReq,
	output var  rrs_pkg::axil_rsp_type  axilRsp,
	// fetch path
	input  wire logic                   insnValid,
	input  wire logic [13:0]            insnWord,
	output logic                        fetchStall,
	// file registers
	output var  rrs_pkg::regfile_req_type regReq,
	input  wire logic [7:0]             regRdData,
	// stack and program counter
	input  wire logic [PC_W-1:0]        stackTopEntry,
	output logic                        stackPop,
	output logic                        pcLoad,
	output logic [PC_W-1:0]             pcNext,
	// watchdog and clocking
	output logic                        watchdogCounterClear,
	output logic                        prescalerClear,
	output logic                        oscHalt,
	input  wire logic                   wakeReq,
	// status bits
	output logic [7:0]                  accum,
	output logic                        carry,
	output logic                        timeoutFlag,
	output logic                        powerDownFlag
);
	import rrs_pkg::*;

	// sequencer state
	op_state_type         state_ff;
	op_state_type         nxt_state;
	logic [1:0]           phase_ff;
	logic [1:0]           nxt_phase;
	logic                 fetchStall_ff;
	logic                 nxt_fetchStall;

	// datapath state
	logic                 rotLeft_ff;
	logic                 nxt_rotLeft;
	logic                 dest_ff;
	logic                 nxt_dest;
	logic [7:0]           operand_ff;
	logic [7:0]           nxt_operand;
	logic [7:0]           result_ff;
	logic [7:0]           nxt_result;
	logic                 resCarry_ff;
	logic                 nxt_resCarry;
	regfile_req_type      regReq_ff;
	regfile_req_type      nxt_regReq;
	logic                 stackPop_ff;
	logic                 nxt_stackPop;
	logic                 pcLoad_ff;
	logic                 nxt_pcLoad;
	logic [PC_W-1:0]      pcNext_ff;
	logic [PC_W-1:0]      nxt_pcNext;
	logic                 wdtClear_ff;
	logic                 nxt_wdtClear;
	logic                 prescClear_ff;
	logic                 nxt_prescClear;
	logic                 oscHalt_ff;
	logic                 nxt_oscHalt;
	logic [7:0]           accum_ff;
	logic [7:0]           nxt_accum;
	logic                 carry_ff;
	logic                 nxt_carry;
	logic                 timeout_ff;
	logic                 nxt_timeout;
	logic                 powerDown_ff;
	logic                 nxt_powerDown;

	// bus slave state
	axil_rsp_type         axilRsp_ff;
	axil_rsp_type         nxt_axilRsp;
	logic                 awHeld_ff;
	logic                 nxt_awHeld;
	logic [`RRS_ADDR_W-1:0] awAddr_ff;
	logic [`RRS_ADDR_W-1:0] nxt_awAddr;
	logic                 wHeld_ff;
	logic                 nxt_wHeld;
	logic [`RRS_DATA_W-1:0] wData_ff;
	logic [`RRS_DATA_W-1:0] nxt_wData;
	logic [`RRS_DATA_W/8-1:0] wStrb_ff;
	logic [`RRS_DATA_W/8-1:0] nxt_wStrb;
	logic                 ctrlEn_ff;
	logic                 nxt_ctrlEn;
	logic                 swWake;
	logic                 doWrite;

	// decode of the word offered in the first phase
	logic                 takeInsn;
	logic                 isRet;
	logic                 isSlp;
	logic                 isRotL;
	logic                 isRotR;

	assign takeInsn = state_ff == ST_IDLE && phase_ff == `RRS_Q1 && insnValid && ctrlEn_ff;
	assign isRet    = insnWord == `RRS_OP_RETURN;
	assign isSlp    = insnWord == `RRS_OP_SLEEP;
	assign isRotL   = insnWord[13:8] == `RRS_ROT_LEFT_PFX;
	assign isRotR   = insnWord[13:8] == `RRS_ROT_RIGHT_PFX;

	// sequencer next state, phase counter and stall
	always_comb begin
		nxt_state = state_ff;
		nxt_phase = 2'(phase_ff + 2'h1);
		case (state_ff)
			ST_IDLE: begin
				if (takeInsn) begin
					if (isRet)
						nxt_state = ST_RET1;
					else if (isSlp)
						nxt_state = ST_SLP1;
					else if (isRotL || isRotR)
						nxt_state = ST_ROT;
				end
			end
			ST_ROT: begin
				if (phase_ff == `RRS_Q4)
					nxt_state = ST_IDLE;
			end
			ST_RET1: begin
				if (phase_ff == `RRS_Q4)
					nxt_state = ST_RET2;
			end
			ST_RET2: begin
				if (phase_ff == `RRS_Q4)
					nxt_state = ST_IDLE;
			end
			ST_SLP1: begin
				if (phase_ff == `RRS_Q4)
					nxt_state = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wakeReq || swWake) begin
					nxt_state = ST_IDLE;
					nxt_phase = `RRS_Q1;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		nxt_fetchStall = nxt_state == ST_RET2 || nxt_state == ST_SLEEP;
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_ff      <= ST_IDLE;
			phase_ff      <= `RRS_Q1;
			fetchStall_ff <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			phase_ff      <= nxt_phase;
			fetchStall_ff <= nxt_fetchStall;
		end
	end

	// datapath next values, strobes default to one-clock pulses
	always_comb begin
		nxt_rotLeft    = rotLeft_ff;
		nxt_dest       = dest_ff;
		nxt_operand    = operand_ff;
		nxt_result     = result_ff;
		nxt_resCarry   = resCarry_ff;
		nxt_regReq     = regReq_ff;
		nxt_regReq.rdEn = 1'b0;
		nxt_regReq.wrEn = 1'b0;
		nxt_stackPop   = 1'b0;
		nxt_pcLoad     = 1'b0;
		nxt_pcNext     = pcNext_ff;
		nxt_wdtClear   = 1'b0;
		nxt_prescClear = 1'b0;
		nxt_oscHalt    = oscHalt_ff;
		nxt_accum      = accum_ff;
		nxt_carry      = carry_ff;
		nxt_timeout    = timeout_ff;
		nxt_powerDown  = powerDown_ff;
		// first phase: latch fields, request the operand
		if (takeInsn && (isRotL || isRotR)) begin
			nxt_rotLeft     = isRotL;
			nxt_dest        = insnWord[`RRS_DEST_BIT];
			nxt_regReq.addr = insnWord[6:0];
			nxt_regReq.rdEn = 1'b1;
		end
		case (state_ff)
			ST_ROT: begin
				if (phase_ff == `RRS_Q2)
					nxt_operand = regRdData;
				if (phase_ff == `RRS_Q3) begin
					if (rotLeft_ff) begin
						nxt_result   = {operand_ff[6:0], carry_ff};
						nxt_resCarry = operand_ff[7];
					end else begin
						nxt_result   = {carry_ff, operand_ff[7:1]};
						nxt_resCarry = operand_ff[0];
					end
					nxt_regReq.wrEn   = dest_ff;
					nxt_regReq.wrData = rotLeft_ff ? {operand_ff[6:0], carry_ff}
						: {carry_ff, operand_ff[7:1]};
				end
				if (phase_ff == `RRS_Q4) begin
					nxt_carry = resCarry_ff;
					if (!dest_ff)
						nxt_accum = result_ff;
				end
			end
			ST_RET1: begin
				if (phase_ff == `RRS_Q3) begin
					nxt_stackPop = 1'b1;
					nxt_pcLoad   = 1'b1;
					nxt_pcNext   = stackTopEntry;
				end
			end
			ST_SLP1: begin
				if (phase_ff == `RRS_Q3) begin
					nxt_wdtClear   = 1'b1;
					nxt_prescClear = 1'b1;
				end
				if (phase_ff == `RRS_Q4) begin
					nxt_timeout   = 1'b1;
					nxt_powerDown = 1'b0;
					nxt_oscHalt   = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (wakeReq || swWake)
					nxt_oscHalt = 1'b0;
			end
			default: begin
			end
		endcase
	end

	// datapath registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rotLeft_ff    <= 1'b0;
			dest_ff       <= 1'b0;
			operand_ff    <= 8'h00;
			result_ff     <= 8'h00;
			resCarry_ff   <= 1'b0;
			regReq_ff     <= '0;
			stackPop_ff   <= 1'b0;
			pcLoad_ff     <= 1'b0;
			pcNext_ff     <= '0;
			wdtClear_ff   <= 1'b0;
			prescClear_ff <= 1'b0;
			oscHalt_ff    <= 1'b0;
			accum_ff      <= `RRS_ACCUM_RESET;
			carry_ff      <= `RRS_CARRY_RESET;
			timeout_ff    <= `RRS_TIMEOUT_RESET;
			powerDown_ff  <= `RRS_PDOWN_RESET;
		end else begin
			rotLeft_ff    <= nxt_rotLeft;
			dest_ff       <= nxt_dest;
			operand_ff    <= nxt_operand;
			result_ff     <= nxt_result;
			resCarry_ff   <= nxt_resCarry;
			regReq_ff     <= nxt_regReq;
			stackPop_ff   <= nxt_stackPop;
			pcLoad_ff     <= nxt_pcLoad;
			pcNext_ff     <= nxt_pcNext;
			wdtClear_ff   <= nxt_wdtClear;
			prescClear_ff <= nxt_prescClear;
			oscHalt_ff    <= nxt_oscHalt;
			accum_ff      <= nxt_accum;
			carry_ff      <= nxt_carry;
			timeout_ff    <= nxt_timeout;
			powerDown_ff  <= nxt_powerDown;
		end
	end

	// bus slave: address and data taken in either order, one of each held
	always_comb begin
		nxt_axilRsp = axilRsp_ff;
		nxt_awHeld  = awHeld_ff;
		nxt_awAddr  = awAddr_ff;
		nxt_wHeld   = wHeld_ff;
		nxt_wData   = wData_ff;
		nxt_wStrb   = wStrb_ff;
		nxt_ctrlEn  = ctrlEn_ff;
		swWake      = 1'b0;
		doWrite     = awHeld_ff && wHeld_ff && !axilRsp_ff.bvalid;
		if (axilReq.awvalid && axilRsp_ff.awready) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = axilReq.awaddr;
		end
		if (axilReq.wvalid && axilRsp_ff.wready) begin
			nxt_wHeld = 1'b1;
			nxt_wData = axilReq.wdata;
			nxt_wStrb = axilReq.wstrb;
		end
		if (axilRsp_ff.bvalid && axilReq.bready)
			nxt_axilRsp.bvalid = 1'b0;
		if (doWrite) begin
			nxt_awHeld         = 1'b0;
			nxt_wHeld          = 1'b0;
			nxt_axilRsp.bvalid = 1'b1;
			nxt_axilRsp.bresp  = `RRS_RESP_OKAY;
			case (awAddr_ff)
				`RRS_REG_CTRL: begin
					if (wStrb_ff[0]) begin
						nxt_ctrlEn = wData_ff[`RRS_CTRL_EN_BIT];
						swWake     = wData_ff[`RRS_CTRL_WAKE_BIT];
					end
				end
				`RRS_REG_STATUS, `RRS_REG_ACCUM, `RRS_REG_LASTPC: begin
				end
				default: nxt_axilRsp.bresp = `RRS_RESP_SLVERR;
			endcase
		end
		// reads answer one clock after the address is taken
		if (axilRsp_ff.rvalid && axilReq.rready)
			nxt_axilRsp.rvalid = 1'b0;
		if (axilReq.arvalid && axilRsp_ff.arready) begin
			nxt_axilRsp.rvalid = 1'b1;
			nxt_axilRsp.rresp  = `RRS_RESP_OKAY;
			nxt_axilRsp.rdata  = '0;
			case (axilReq.araddr)
				`RRS_REG_CTRL:   nxt_axilRsp.rdata[0] = ctrlEn_ff;
				`RRS_REG_STATUS: nxt_axilRsp.rdata[4:0] = {state_ff != ST_IDLE,
					state_ff == ST_SLEEP, powerDown_ff, timeout_ff, carry_ff};
				`RRS_REG_ACCUM:  nxt_axilRsp.rdata[7:0] = accum_ff;
				`RRS_REG_LASTPC: nxt_axilRsp.rdata[PC_W-1:0] = pcNext_ff;
				default:         nxt_axilRsp.rresp = `RRS_RESP_SLVERR;
			endcase
		end
		nxt_axilRsp.awready = !nxt_awHeld && !nxt_axilRsp.bvalid;
		nxt_axilRsp.wready  = !nxt_wHeld && !nxt_axilRsp.bvalid;
		nxt_axilRsp.arready = !nxt_axilRsp.rvalid;
	end

	// bus slave registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			axilRsp_ff <= '0;
			awHeld_ff  <= 1'b0;
			awAddr_ff  <= '0;
			wHeld_ff   <= 1'b0;
			wData_ff   <= '0;
			wStrb_ff   <= '0;
			ctrlEn_ff  <= `RRS_CTRL_EN_RESET;
		end else begin
			axilRsp_ff <= nxt_axilRsp;
			awHeld_ff  <= nxt_awHeld;
			awAddr_ff  <= nxt_awAddr;
			wHeld_ff   <= nxt_wHeld;
			wData_ff   <= nxt_wData;
			wStrb_ff   <= nxt_wStrb;
			ctrlEn_ff  <= nxt_ctrlEn;
		end
	end

	// outputs straight from flops
	assign axilRsp              = axilRsp_ff;
	assign fetchStall           = fetchStall_ff;
	assign regReq               = regReq_ff;
	assign stackPop             = stackPop_ff;
	assign pcLoad               = pcLoad_ff;
	assign pcNext               = pcNext_ff;
	assign watchdogCounterClear = wdtClear_ff;
	assign prescalerClear       = prescClear_ff;
	assign oscHalt              = oscHalt_ff;
	assign accum                = accum_ff;
	assign carry                = carry_ff;
	assign timeoutFlag          = timeout_ff;
	assign powerDownFlag        = powerDown_ff;

	// checks on the sequencer and datapath
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	AST_RET_POP:
	assert property ((state_ff == ST_RET1 && phase_ff == `RRS_Q3) |=>
		(stackPop_ff && pcLoad_ff && pcNext_ff == $past(stackTopEntry)))
		else $error("return did not load stack top into pc");
	AST_RET_STATUS:
	assert property ((takeInsn && isRet) |=>
		($stable(carry_ff) && $stable(timeout_ff) && $stable(powerDown_ff))[*7])
		else $error("return changed a status bit");
	AST_RET_TWO_CYCLES:
	assert property (stackPop_ff |-> (state_ff == ST_RET1 && phase_ff == `RRS_Q4) ##1
		(state_ff == ST_RET2 && !regReq_ff.wrEn && !pcLoad_ff)[*4] ##1 state_ff == ST_IDLE)
		else $error("return did not take two idle-ended cycles");
	AST_ROT_LEFT:
	assert property ((state_ff == ST_ROT && rotLeft_ff && phase_ff == `RRS_Q3) |=>
		result_ff == {$past(operand_ff[6:0]), $past(carry_ff)})
		else $error("left rotate result wrong");
	AST_ROT_LEFT_DEST:
	assert property ((state_ff == ST_ROT && rotLeft_ff && phase_ff == `RRS_Q4) |=>
		(dest_ff ? $past(regReq_ff.wrEn) : (!$past(regReq_ff.wrEn) &&
		accum_ff == $past(result_ff))))
		else $error("left rotate sent to wrong destination");
	AST_ROT_RIGHT:
	assert property ((state_ff == ST_ROT && !rotLeft_ff && phase_ff == `RRS_Q3) |=>
		result_ff == {$past(carry_ff), $past(operand_ff[7:1])})
		else $error("right rotate result wrong");
	AST_ROT_RIGHT_DEST:
	assert property ((state_ff == ST_ROT && !rotLeft_ff && phase_ff == `RRS_Q3 && dest_ff)
		|=> (regReq_ff.wrEn && regReq_ff.wrData == {$past(carry_ff), $past(operand_ff[7:1])}))
		else $error("right rotate write-back wrong");
	AST_ROT_PHASES:
	assert property ((takeInsn && (isRotL || isRotR)) |=>
		(regReq_ff.rdEn && phase_ff == `RRS_Q2) ##1 !regReq_ff.rdEn ##1
		(phase_ff == `RRS_Q4 && regReq_ff.wrEn == dest_ff) ##1 state_ff == ST_IDLE)
		else $error("rotate did not run in one instruction cycle");
	AST_SLEEP_FLAGS:
	assert property ((state_ff == ST_SLP1 && phase_ff == `RRS_Q4) |=>
		(timeout_ff && !powerDown_ff))
		else $error("sleep flags wrong");
	AST_SLEEP_WDT:
	assert property ((state_ff == ST_SLP1 && phase_ff == `RRS_Q3) |=>
		(wdtClear_ff && prescClear_ff) ##1 !wdtClear_ff)
		else $error("sleep did not clear watchdog");
	AST_SLEEP_HALT:
	assert property ((state_ff == ST_SLP1 && phase_ff == `RRS_Q4) |=>
		(oscHalt_ff && fetchStall_ff && state_ff == ST_SLEEP))
		else $error("sleep did not halt oscillator");
	AST_ROT_CARRY:
	assert property ((state_ff == ST_ROT && phase_ff == `RRS_Q4) |=>
		carry_ff == ($past(rotLeft_ff) ? $past(operand_ff[7]) : $past(operand_ff[0])))
		else $error("rotate carry wrong");

endmodule : return_rotate_sleep_ops
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the return, rotate and sleep block
`timescale 1ns/1ps
`default_nettype none
`include "rrs_params.svh"

module tb;
	import rrs_pkg::*;

	// one rotate case: instruction word and register operand
	typedef struct packed {
		logic [13:0] word;
		logic [7:0]  operand;
		logic [7:0]  result;
		logic        carryOut;
	} row_type;

	logic            clk_sys;
	logic            reset_n;
	axil_req_type    axilReq;
	axil_rsp_type    axilRsp;
	logic            insnValid;
	logic [13:0]     insnWord;
	logic            fetchStall;
	regfile_req_type regReq;
	logic [7:0]      regRdData;
	logic [12:0]     stackTopEntry;
	logic            stackPop;
	logic            pcLoad;
	logic [12:0]     pcNext;
	logic            watchdogCounterClear;
	logic            prescalerClear;
	logic            oscHalt;
	logic            wakeReq;
	logic [7:0]      accum;
	logic            carry;
	logic            timeoutFlag;
	logic            powerDownFlag;
	logic [1:0]      tbPhase;
	logic [7:0]      expAcc;
	logic [7:0]      expRes;
	logic            expCarry;
	logic [31:0]     rdWord;
	logic [1:0]      resp;
	int              nFail;
	int              checksDone;
	row_type         rows [6];

	return_rotate_sleep_ops #(.PC_W(13)) u_dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .axilReq(axilReq), .axilRsp(axilRsp),
		.insnValid(insnValid), .insnWord(insnWord), .fetchStall(fetchStall),
		.regReq(regReq), .regRdData(regRdData), .stackTopEntry(stackTopEntry),
		.stackPop(stackPop), .pcLoad(pcLoad), .pcNext(pcNext),
		.watchdogCounterClear(watchdogCounterClear), .prescalerClear(prescalerClear),
		.oscHalt(oscHalt), .wakeReq(wakeReq), .accum(accum), .carry(carry),
		.timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag)
	);

	// 10 MHz core clock
	initial clk_sys = 1'b0;
	always #50 clk_sys = ~clk_sys;

	// bench copy of the phase counter, held at Q1 while halted so any wake restarts it
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) tbPhase <= 2'h0;
		else if (oscHalt) tbPhase <= 2'h0;
		else tbPhase <= tbPhase + 2'h1;
	end

	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checksDone++;
		if (seen !== exp) begin
			nFail++;
			$display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask : chk

	task automatic printVerdict;
		if (nFail == 0 && checksDone > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : printVerdict

	task automatic giveUp(input string msg);
		nFail++;
		$display("MISMATCH %0t timeout %s", $time, msg);
		printVerdict;
	endtask : giveUp

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	// hold reset, check reset levels, release
	task automatic doReset(input int n);
		@(posedge clk_sys);
		reset_n <= 1'b0;
		cyc(n);
		chk(32'(powerDownFlag), 1, "pd at reset");
		chk(32'(timeoutFlag), 1, "to at reset");
		chk(32'({accum, carry, oscHalt, fetchStall}), 0, "core at reset");
		chk(32'(axilRsp.awready), 0, "ready at reset");
		@(posedge clk_sys);
		reset_n <= 1'b1;
		cyc(3);
		expAcc = 8'h00;
		expCarry = 1'b0;
	endtask : doReset

	task automatic axiWrite(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] er);
		int i;
		@(posedge clk_sys);
		axilReq.awvalid <= 1'b1;
		axilReq.awaddr <= addr;
		axilReq.wvalid <= 1'b1;
		axilReq.wdata <= data;
		axilReq.wstrb <= 4'hF;
		axilReq.bready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (axilReq.awvalid && axilRsp.awready) axilReq.awvalid <= 1'b0;
			if (axilReq.wvalid && axilRsp.wready) axilReq.wvalid <= 1'b0;
			if (axilRsp.bvalid) break;
		end
		if (i == 20) giveUp("write");
		chk(32'(axilRsp.bresp), 32'(er), "bresp");
		axilReq.bready <= 1'b0;
		#1;
	endtask : axiWrite

	task automatic axiRead(input logic [31:0] addr);
		int i;
		@(posedge clk_sys);
		axilReq.arvalid <= 1'b1;
		axilReq.araddr <= addr;
		axilReq.rready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (axilReq.arvalid && axilRsp.arready) axilReq.arvalid <= 1'b0;
			if (axilRsp.rvalid) break;
		end
		if (i == 20) giveUp("read");
		rdWord = axilRsp.rdata;
		resp = axilRsp.rresp;
		axilReq.rready <= 1'b0;
		#1;
	endtask : axiRead

	// wait for the Q4 cycle so the next edge opens Q1
	task automatic syncQ4;
		int i;
		for (i = 0; i < 12 && tbPhase !== 2'h3; i++) cyc(1);
		if (tbPhase !== 2'h3) giveUp("phase");
	endtask : syncQ4

	// one rotate offered in Q1; checks the previous result at its Q1
	task automatic runRow(input logic [13:0] word, input logic [7:0] op, input logic taken);
		logic [7:0] res;
		logic       newC;
		logic       d;
		d = word[`RRS_DEST_BIT];
		res = word[8] ? {op[6:0], expCarry} : {expCarry, op[7:1]};
		newC = word[8] ? op[7] : op[0];
		@(posedge clk_sys);
		insnValid <= 1'b1;
		insnWord <= word;
		regRdData <= op;
		#1;
		chk(32'(accum), 32'(expAcc), "accum");
		chk(32'(carry), 32'(expCarry), "carry");
		@(posedge clk_sys);
		insnValid <= 1'b0;
		#1;
		chk(32'(regReq.rdEn), 32'(taken), "read strobe");
		if (taken) chk(32'(regReq.addr), 32'(word[6:0]), "read addr");
		@(posedge clk_sys);
		regRdData <= ~op;
		cyc(1);
		chk(32'(regReq.wrEn), 32'(taken & d), "write strobe");
		if (taken & d) chk(32'(regReq.wrData), 32'(res), "write data");
		if (taken) expCarry = newC;
		if (taken && !d) expAcc = res;
		expRes = res;
	endtask : runRow

	// main sequence
	initial begin
		reset_n = 1'b0;
		axilReq = '0;
		insnValid = 1'b0;
		insnWord = '0;
		regRdData = '0;
		stackTopEntry = '0;
		wakeReq = 1'b0;
		nFail = 0;
		checksDone = 0;
		rows = '{'{14'h0D11, 8'hE6, 8'hCC, 1'b1}, '{14'h0C11, 8'hE6, 8'hF3, 1'b0},
			'{14'h0DA2, 8'h81, 8'h02, 1'b1}, '{14'h0CA2, 8'h01, 8'h80, 1'b1},
			'{14'h0DFF, 8'h80, 8'h01, 1'b1}, '{14'h0C00, 8'h00, 8'h80, 1'b0}};
		doReset(20);
		axiRead(`RRS_REG_CTRL);
		chk(rdWord, 1, "ctrl reset");
		axiRead(`RRS_REG_STATUS);
		chk(rdWord, 32'h06, "status reset");
		// back-to-back rotates in both directions and destinations
		syncQ4;
		foreach (rows[i]) begin
			runRow(rows[i].word, rows[i].operand, 1'b1);
			chk(32'({expRes, expCarry}), 32'({rows[i].result, rows[i].carryOut}), "row");
		end
		cyc(1);
		chk(32'({accum, carry}), 32'({expAcc, expCarry}), "last rotate");
		chk(32'({timeoutFlag, powerDownFlag}), 32'h3, "flags kept");
		axiRead(`RRS_REG_STATUS);
		chk(rdWord & 32'h1F, 32'h06 | 32'(expCarry), "status");
		// refused while disabled; read-only and unmapped places
		axiWrite(`RRS_REG_CTRL, 0, `RRS_RESP_OKAY);
		syncQ4;
		runRow(14'h0D11, 8'h55, 1'b0);
		axiWrite(`RRS_REG_CTRL, 1, `RRS_RESP_OKAY);
		axiWrite(`RRS_REG_ACCUM, 32'hFF, `RRS_RESP_OKAY);
		axiRead(`RRS_REG_ACCUM);
		chk(rdWord, 32'(expAcc), "accum read-only");
		axiWrite(32'h0000_0040, 1, `RRS_RESP_SLVERR);
		axiRead(32'h0000_0040);
		chk(rdWord, 0, "unmapped data");
		chk(32'(resp), 32'(`RRS_RESP_SLVERR), "unmapped resp");
		// return: pop in Q4, idle second cycle refuses an instruction
		syncQ4;
		@(posedge clk_sys);
		insnValid <= 1'b1;
		insnWord <= `RRS_OP_RETURN;
		stackTopEntry <= 13'h1A5C;
		@(posedge clk_sys);
		insnValid <= 1'b0;
		#1;
		chk(32'(stackPop), 0, "early pop");
		@(posedge clk_sys);
		@(posedge clk_sys);
		stackTopEntry <= 13'h05A3;
		#1;
		chk(32'({stackPop, pcLoad}), 32'h3, "pop and load");
		chk(32'(pcNext), 32'h1A5C, "pc value");
		@(posedge clk_sys);
		insnValid <= 1'b1;
		insnWord <= 14'h0D11;
		#1;
		chk(32'({stackPop, fetchStall}), 32'h1, "second cycle");
		@(posedge clk_sys);
		insnValid <= 1'b0;
		#1;
		chk(32'(regReq.rdEn), 0, "refused in stall");
		cyc(2);
		chk(32'({carry, timeoutFlag, powerDownFlag}), 32'({expCarry, 2'h3}), "status");
		runRow(14'h0CA2, 8'h5A, 1'b1);
		axiRead(`RRS_REG_LASTPC);
		chk(rdWord, 32'h1A5C, "last pc");
		// sleep, then wake by pin
		syncQ4;
		@(posedge clk_sys);
		insnValid <= 1'b1;
		insnWord <= `RRS_OP_SLEEP;
		@(posedge clk_sys);
		insnValid <= 1'b0;
		cyc(1);
		chk(32'(watchdogCounterClear), 0, "early clear");
		cyc(1);
		chk(32'({watchdogCounterClear, prescalerClear}), 32'h3, "clears");
		chk(32'(oscHalt), 0, "halt early");
		cyc(1);
		chk(32'({timeoutFlag, powerDownFlag}), 32'h2, "sleep flags");
		chk(32'({oscHalt, fetchStall}), 32'h3, "halted");
		chk(32'(watchdogCounterClear), 0, "clear pulse");
		axiRead(`RRS_REG_STATUS);
		chk(rdWord & 32'h1F, 32'h1A | 32'(expCarry), "sleep status");
		cyc(3);
		chk(32'(oscHalt), 1, "stays halted");
		@(posedge clk_sys);
		wakeReq <= 1'b1;
		@(posedge clk_sys);
		wakeReq <= 1'b0;
		#1;
		chk(32'({oscHalt, fetchStall}), 0, "woken");
		syncQ4;
		runRow(14'h0D33, 8'h0F, 1'b1);
		// sleep again, wake by control write
		syncQ4;
		@(posedge clk_sys);
		insnValid <= 1'b1;
		insnWord <= `RRS_OP_SLEEP;
		@(posedge clk_sys);
		insnValid <= 1'b0;
		cyc(4);
		chk(32'(oscHalt), 1, "halted again");
		axiWrite(`RRS_REG_CTRL, 32'h3, `RRS_RESP_OKAY);
		chk(32'({oscHalt, fetchStall}), 0, "woken by write");
		syncQ4;
		runRow(14'h0C33, 8'hF0, 1'b1);
		// second reset in mid-run, then work again
		doReset(2);
		syncQ4;
		runRow(14'h0C05, 8'h3C, 1'b1);
		cyc(1);
		chk(32'({accum, carry}), 32'({expAcc, expCarry}), "after reset");
		printVerdict;
	end

endmodule : tb
`default_nettype wire
